/* design/dsgm_top.sv */
// dsgm_top: keying mixer with its four registers on an Avalon-MM slave.
// Assumes peripheral sources run on core_clk; the comparator and the three
// input pins are asynchronous and are synchronised here.
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dsgm_top
    import dsgm_pkg::*;
#(
    parameter int ADDR_W = 4
)(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pwm_out,
    input wire logic spi_data_out,
    input wire logic cmp_out,
    input wire logic uart_tx,
    input wire logic reference_clock_output,
    input wire logic data_input_pin,
    input wire logic carrier_input_pin_one,
    input wire logic carrier_input_pin_two,
    output logic keyed_pin,
    output logic slew_limit,
    output dsgm_inhibit_t periph_pin_inhibit
);
    if (ADDR_W < 4)
    begin : g_addr_check
        $error("ADDR_W must reach the highest register offset");
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    logic [3:0] async_in;
    logic [3:0] meta_r;
    logic [3:0] sync_r;

    assign async_in = {cmp_out, data_input_pin, carrier_input_pin_one,
                       carrier_input_pin_two};

    // two flops per asynchronous input; the first feeds only the second
    for (genvar i = 0; i < 4; i++)
    begin : g_sync
        always_ff @(posedge core_clk)
        begin
            if (!rst_n)
            begin
                meta_r[i] <= 1'b0;
                sync_r[i] <= 1'b0;
            end
            else if (ce)
            begin
                meta_r[i] <= async_in[i];
                sync_r[i] <= meta_r[i];
            end
        end
    end

    dsgm_src_t src;

    // sources keep running without a bus clock, so sleep changes nothing
    always_comb
    begin
        src.pwm = pwm_out;
        src.spi = spi_data_out;
        src.cmp = sync_r[3];
        src.uart = uart_tx;
        src.ref_clk = reference_clock_output;
        src.pin_data = sync_r[2];
        src.pin_c1 = sync_r[1];
        src.pin_c2 = sync_r[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and bus slave

    logic [7:0] ctrl_r;
    logic [7:0] src_r;
    dsgm_car_t high_carrier_r;
    dsgm_car_t low_carrier_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [7:0] rd_byte;
    logic wr_go;
    logic mix;

    // a write lands at the edge where the master sees waitrequest low
    assign wr_go = ce && avs_write && !wait_r && avs_byteenable[0];

    // one wait cycle for every access, then one cycle of waitrequest low
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            wait_r <= 1'b1;
        else if (ce)
            wait_r <= !((avs_read || avs_write) && wait_r);
    end

    // read word sampled while waitrequest is still high
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdata_r <= 32'h00000000;
        else if (ce && avs_read && wait_r)
            rdata_r <= {24'h000000, rd_byte};
    end

    // unmapped offsets read zero and ignore writes
    always_comb
    begin
        rd_byte = 8'h00;
        case (avs_address)
            ADDR_W'(DSGM_OFS_CTRL):
            begin
                rd_byte = ctrl_r;
                rd_byte[DSGM_CTRL_OUT] = mix;
            end
            ADDR_W'(DSGM_OFS_SRC): rd_byte = src_r;
            ADDR_W'(DSGM_OFS_HIGH_CARRIER): rd_byte = high_carrier_r;
            ADDR_W'(DSGM_OFS_LOW_CARRIER): rd_byte = low_carrier_r;
            default: rd_byte = 8'h00;
        endcase
    end

    // clearing the enable touches no selection register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrl_r <= DSGM_CTRL_RST;
            src_r <= DSGM_SRC_RST;
            high_carrier_r <= DSGM_CAR_RST;
            low_carrier_r <= DSGM_CAR_RST;
        end
        else if (wr_go)
        begin
            if (avs_address == ADDR_W'(DSGM_OFS_CTRL))
                ctrl_r <= avs_writedata[7:0] & DSGM_CTRL_WMASK;
            if (avs_address == ADDR_W'(DSGM_OFS_SRC))
                src_r <= avs_writedata[7:0] & DSGM_SRC_WMASK;
            if (avs_address == ADDR_W'(DSGM_OFS_HIGH_CARRIER))
                high_carrier_r <= avs_writedata[7:0] & DSGM_CAR_WMASK;
            if (avs_address == ADDR_W'(DSGM_OFS_LOW_CARRIER))
                low_carrier_r <= avs_writedata[7:0] & DSGM_CAR_WMASK;
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // source selection

    logic enable;
    logic mod;
    logic high_carrier;
    logic low_carrier;

    assign enable = ctrl_r[DSGM_CTRL_EN];

    // disabled: software bit is the modulator whatever the field holds
    always_comb
    begin
        mod = 1'b0;
        if (!enable)
            mod = ctrl_r[DSGM_CTRL_SW];
        else
        begin
            case (src_r[3:0])
                DSGM_MS_SW: mod = ctrl_r[DSGM_CTRL_SW];
                DSGM_MS_PIN: mod = src.pin_data;
                DSGM_MS_PWM: mod = src.pwm;
                DSGM_MS_CMP: mod = src.cmp;
                DSGM_MS_SPI: mod = src.spi;
                DSGM_MS_UART: mod = src.uart;
                default: mod = 1'b0;
            endcase
        end
    end

    // high and low carriers decoded independently
    dsgm_car_sel #(.LOW_SIDE(1'b0)) u_high_carrier (
        .active(enable),
        .cfg(high_carrier_r),
        .src(src),
        .carrier(high_carrier)
    );
    dsgm_car_sel #(.LOW_SIDE(1'b1)) u_low_carrier (
        .active(enable),
        .cfg(low_carrier_r),
        .src(src),
        .carrier(low_carrier)
    );

    dsgm_keyer u_keyer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .active(enable),
        .mod(mod),
        .high_carrier(high_carrier),
        .low_carrier(low_carrier),
        .sync_h(high_carrier_r.sync),
        .sync_l(low_carrier_r.sync),
        .use_high_r(),
        .mix_r(mix)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin side

    logic pin_r;
    dsgm_inhibit_t inh_nxt;
    dsgm_inhibit_t inh_r;
    logic ms_dis;

    // a disabled mixer has no output, so the pin also rests low then
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            pin_r <= 1'b0;
        else if (ce)
            pin_r <= enable && ctrl_r[DSGM_CTRL_OE]
                     && (mix ^ ctrl_r[DSGM_CTRL_INV]);
    end

    assign ms_dis = src_r[DSGM_SRC_PDIS];

    // pin release follows the bits even while the mixer is disabled
    always_comb
    begin
        inh_nxt.pwm = (ms_dis && src_r[3:0] == DSGM_MS_PWM)
                      || (high_carrier_r.pin_disable && high_carrier_r.sel == DSGM_CS_PWM)
                      || (low_carrier_r.pin_disable && low_carrier_r.sel == DSGM_CS_PWM);
        inh_nxt.spi = ms_dis && src_r[3:0] == DSGM_MS_SPI;
        inh_nxt.cmp = ms_dis && src_r[3:0] == DSGM_MS_CMP;
        inh_nxt.uart = ms_dis && src_r[3:0] == DSGM_MS_UART;
        inh_nxt.ref_clk = (high_carrier_r.pin_disable && high_carrier_r.sel == DSGM_CS_REF)
                          || (low_carrier_r.pin_disable && low_carrier_r.sel == DSGM_CS_REF);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            inh_r <= '0;
        else if (ce)
            inh_r <= inh_nxt;
    end

    assign keyed_pin = pin_r;
    assign slew_limit = ctrl_r[DSGM_CTRL_SLR];
    assign periph_pin_inhibit = inh_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking tc @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence ctrl_read_s;
        ce && avs_read && wait_r && avs_address == ADDR_W'(DSGM_OFS_CTRL);
    endsequence

    sequence write_done_s;
        ce && avs_write && wait_r ##1 ce && avs_write && !wait_r;
    endsequence

    pin_low_a: assert property (
        ce && !ctrl_r[DSGM_CTRL_OE] |=> !keyed_pin)
        else $error("output pin driven while pin drive is off");
    pin_invert_a: assert property (
        ce && enable && ctrl_r[DSGM_CTRL_OE]
        |=> keyed_pin == ($past(mix) ^ $past(ctrl_r[DSGM_CTRL_INV])))
        else $error("output pin not the keyed result with its polarity");
    status_mirror_a: assert property (
        ctrl_read_s |=> avs_readdata[DSGM_CTRL_OUT] == $past(mix))
        else $error("status bit does not show the keyed result");
    disabled_ground_a: assert property (
        !enable |-> !high_carrier && !low_carrier && mod == ctrl_r[DSGM_CTRL_SW])
        else $error("disabled mixer still takes selected sources");
    select_keep_a: assert property (
        ce && avs_address == ADDR_W'(DSGM_OFS_CTRL) ##0 write_done_s
        |=> src_r == $past(src_r) && high_carrier_r == $past(high_carrier_r))
        else $error("control write disturbed source selections");
    reserved_quiet_a: assert property (
        enable && src_r[3:0] inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'hB,
        4'hC, 4'hD, 4'hE, 4'hF} |-> !mod)
        else $error("reserved modulator code not held low");
    reset_default_a: assert property (
        $rose(rst_n) |-> slew_limit && !enable && !keyed_pin)
        else $error("registers not at defaults after reset");
    bus_answer_a: assert property (
        ce && (avs_read || avs_write) && wait_r |=> !avs_waitrequest ##1 wait_r)
        else $error("bus answer not given after one wait cycle");
    low_pin_two_a: assert property (
        enable && low_carrier_r.sel == DSGM_CS_PIN2 |-> !low_carrier || low_carrier_r.invert)
        else $error("low carrier reached the second carrier pin");
endmodule
`default_nettype wire

/* design/dsgm_pkg.sv */
// dsgm_pkg: register map, field layout, source codes and carrier types
// of the keying mixer.
// Assumes one core clock; each 8-bit register sits in the low byte of
// an aligned 32-bit word.
package dsgm_pkg;
    // register byte offsets
    localparam logic [3:0] DSGM_OFS_CTRL = 4'h0;
    localparam logic [3:0] DSGM_OFS_SRC = 4'h4;
    localparam logic [3:0] DSGM_OFS_HIGH_CARRIER = 4'h8;
    localparam logic [3:0] DSGM_OFS_LOW_CARRIER = 4'hC;
    // modulator_control fields
    localparam int DSGM_CTRL_EN = 7;
    localparam int DSGM_CTRL_OE = 6;
    localparam int DSGM_CTRL_SLR = 5;
    localparam int DSGM_CTRL_INV = 4;
    localparam int DSGM_CTRL_OUT = 3;
    localparam int DSGM_CTRL_SW = 0;
    // data_source_register fields
    localparam int DSGM_SRC_PDIS = 7;
    // reset values and writable masks
    localparam logic [7:0] DSGM_CTRL_RST = 8'h20;
    localparam logic [7:0] DSGM_SRC_RST = 8'h00;
    localparam logic [7:0] DSGM_CAR_RST = 8'h00;
    localparam logic [7:0] DSGM_CTRL_WMASK = 8'hF1;
    localparam logic [7:0] DSGM_SRC_WMASK = 8'h8F;
    localparam logic [7:0] DSGM_CAR_WMASK = 8'hEF;
    // modulator source codes
    localparam logic [3:0] DSGM_MS_SW = 4'h0;
    localparam logic [3:0] DSGM_MS_PIN = 4'h1;
    localparam logic [3:0] DSGM_MS_PWM = 4'h2;
    localparam logic [3:0] DSGM_MS_CMP = 4'h6;
    localparam logic [3:0] DSGM_MS_SPI = 4'h8;
    localparam logic [3:0] DSGM_MS_UART = 4'hA;
    // carrier source codes
    localparam logic [3:0] DSGM_CS_GND = 4'h0;
    localparam logic [3:0] DSGM_CS_PIN1 = 4'h1;
    localparam logic [3:0] DSGM_CS_PIN2 = 4'h2;
    localparam logic [3:0] DSGM_CS_REF = 4'h3;
    localparam logic [3:0] DSGM_CS_PWM = 4'h4;

    // carrier register layout, msb first as stored
    typedef struct packed {
        logic pin_disable;
        logic invert;
        logic sync;
        logic unused;
        logic [3:0] sel;
    } dsgm_car_t;

    // every signal the mixer can choose from, in the core clock domain
    typedef struct packed {
        logic pwm;
        logic spi;
        logic cmp;
        logic uart;
        logic ref_clk;
        logic pin_data;
        logic pin_c1;
        logic pin_c2;
    } dsgm_src_t;

    // per-peripheral request to release its default output pin
    typedef struct packed {
        logic pwm;
        logic spi;
        logic cmp;
        logic uart;
        logic ref_clk;
    } dsgm_inhibit_t;
endpackage

/* design/dsgm_car_sel.sv */
// dsgm_car_sel: decodes one carrier selection field into a carrier level.
// Assumes sources are already in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module dsgm_car_sel
    import dsgm_pkg::*;
#(
    parameter bit LOW_SIDE = 1'b0
)(
    input wire logic active,
    input wire dsgm_car_t cfg,
    input wire dsgm_src_t src,
    output logic carrier
);
    logic raw;

    // the low carrier has no path to the second carrier pin
    always_comb
    begin
        raw = 1'b0;
        case (cfg.sel)
            DSGM_CS_GND: raw = 1'b0;
            DSGM_CS_PIN1: raw = src.pin_c1;
            DSGM_CS_PIN2: raw = LOW_SIDE ? 1'b0 : src.pin_c2;
            DSGM_CS_REF: raw = src.ref_clk;
            DSGM_CS_PWM: raw = src.pwm;
            default: raw = 1'b0;
        endcase
    end

    // a disabled mixer sees ground, and while disabled that ground is not inverted
    assign carrier = active & (raw ^ cfg.invert);
endmodule
`default_nettype wire

/* design/dsgm_keyer.sv */
// dsgm_keyer: picks high or low carrier from the modulator, with optional
// wait for the current carrier's falling edge before a switch.
// Assumes all inputs are in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module dsgm_keyer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic active,
    input wire logic mod,
    input wire logic high_carrier,
    input wire logic low_carrier,
    input wire logic sync_h,
    input wire logic sync_l,
    output logic use_high_r,
    output logic mix_r
);
    logic use_high_nxt;
    logic high_carrier_prev_r;
    logic low_carrier_prev_r;
    logic fall_h;
    logic fall_l;

    assign fall_h = high_carrier_prev_r & ~high_carrier;
    assign fall_l = low_carrier_prev_r & ~low_carrier;

    // a carrier stuck low never falls, so sync on it stalls the switch
    always_comb
    begin
        use_high_nxt = use_high_r;
        if (!active)
            use_high_nxt = mod;
        else if (mod != use_high_r)
        begin
            // stay on the current carrier only while its sync waits for a fall
            if (use_high_r)
                use_high_nxt = sync_h && !fall_h;
            else
                use_high_nxt = !(sync_l && !fall_l);
        end
    end

    // selection and mixed level, registered together
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            use_high_r <= 1'b0;
            high_carrier_prev_r <= 1'b0;
            low_carrier_prev_r <= 1'b0;
            mix_r <= 1'b0;
        end
        else if (ce)
        begin
            use_high_r <= use_high_nxt;
            high_carrier_prev_r <= high_carrier;
            low_carrier_prev_r <= low_carrier;
            mix_r <= use_high_nxt ? high_carrier : low_carrier;
        end
    end

    default clocking kc @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence high_fall_s;
        high_carrier_prev_r && !high_carrier;
    endsequence

    sync_hold_a: assert property (
        ce && active && sync_h && use_high_r && !mod && !(high_carrier_prev_r && !high_carrier)
        |=> use_high_r)
        else $error("high carrier switched before its falling edge");
    sync_release_a: assert property (
        ce && active && use_high_r && !mod ##0 high_fall_s |=> !use_high_r)
        else $error("switch not taken at high carrier falling edge");
    mix_select_a: assert property (
        ce && active && !sync_h && !sync_l
        |=> mix_r == ($past(mod) ? $past(high_carrier) : $past(low_carrier)))
        else $error("mixed level does not follow modulator choice");
endmodule
`default_nettype wire

/* tb/dsgm_src_model.sv */
// dsgm_src_model: stands in for the peripherals and input pins that feed the mixer.
// Assumes the bench changes levels just after a rising core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module dsgm_src_model
    import dsgm_pkg::*;
(
    input wire logic core_clk,
    input wire dsgm_src_t lvl,
    input wire dsgm_inhibit_t inhibit,
    output dsgm_src_t src,
    output dsgm_inhibit_t pin_owned
);
    // sources run on regardless of the mixer state, as they would in sleep
    always_ff @(posedge core_clk)
    begin
        src <= lvl;
    end
    // a peripheral told to release its pin stops claiming it
    always_comb
    begin
        pin_owned = ~inhibit;
    end
endmodule
`default_nettype wire

/* tb/data_signal_modulator_test.sv */
// data_signal_modulator_test: register-level bench for the keying mixer.
// Assumes dsgm_top and the source model; one 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module data_signal_modulator_test;
    import dsgm_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic keyed_pin;
    logic slew_limit;
    dsgm_inhibit_t inhibit;
    dsgm_src_t lvl = '0;
    dsgm_src_t src;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] rd;
    logic [3:0] mcode [7] = '{4'h1, 4'h2, 4'h6, 4'h8, 4'hA, 4'h3, 4'hF};
    logic [7:0] mmask [7] = '{8'h04, 8'h80, 8'h20, 8'h40, 8'h10, 8'h00, 8'h00};

    always #2 core_clk = ~core_clk;

    dsgm_src_model src_u (.core_clk(core_clk), .lvl(lvl), .inhibit(inhibit), .src(src),
        .pin_owned());

    dsgm_top #(.ADDR_W(5)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pwm_out(src.pwm), .spi_data_out(src.spi), .cmp_out(src.cmp), .uart_tx(src.uart),
        .reference_clock_output(src.ref_clk), .data_input_pin(src.pin_data),
        .carrier_input_pin_one(src.pin_c1), .carrier_input_pin_two(src.pin_c2),
        .keyed_pin(keyed_pin), .slew_limit(slew_limit), .periph_pin_inhibit(inhibit));

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // a hung handshake must still end in the closing report
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one Avalon access; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
        input logic [3:0] be);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, {1'b0, a}, d, 4'h1);
    endtask

    task automatic rc(input string what, input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, {1'b0, a}, 8'h00, 4'h1);
        chk(what, exp, rd);
    endtask

    // eight cycles cover the two-flop synchronisers plus keyer and pin flops
    task automatic pin_is(input logic exp);
        repeat (8) @(posedge core_clk);
        chk("keyed_pin", {7'h00, exp}, {7'h00, keyed_pin});
    endtask

    task automatic set_lvl(input logic [7:0] v);
        @(posedge core_clk);
        lvl <= v;
    endtask

    task automatic defaults();
        rc("control", DSGM_OFS_CTRL, 8'h20);
        rc("source", DSGM_OFS_SRC, 8'h00);
        rc("high carrier", DSGM_OFS_HIGH_CARRIER, 8'h00);
        rc("low carrier", DSGM_OFS_LOW_CARRIER, 8'h00);
        chk("slew_limit", 8'h01, {7'h00, slew_limit});
        chk("keyed_pin", 8'h00, {7'h00, keyed_pin});
        chk("inhibit", 8'h00, {3'h0, inhibit});
    endtask

    // source levels that each carrier code should pass through
    function automatic logic [7:0] cmask(input int k, input bit low);
        case (k)
            1: return 8'h02;
            2: return low ? 8'h00 : 8'h01;
            3: return 8'h08;
            4: return 8'h80;
            default: return 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        defaults();
        // reserved bits, unmapped place and masked byte lane
        wr(DSGM_OFS_SRC, 8'hFF);
        wr(DSGM_OFS_HIGH_CARRIER, 8'hFF);
        wr(DSGM_OFS_LOW_CARRIER, 8'hFF);
        wr(DSGM_OFS_CTRL, 8'hFF);
        rc("source", DSGM_OFS_SRC, 8'h8F);
        rc("high carrier", DSGM_OFS_HIGH_CARRIER, 8'hEF);
        rc("low carrier", DSGM_OFS_LOW_CARRIER, 8'hEF);
        // reserved low code gives ground, inverted to one; result invert makes it zero
        rc("control", DSGM_OFS_CTRL, 8'hF9);
        pin_is(1'b0);
        bus(1'b1, 5'h10, 8'h55, 4'h1);
        bus(1'b0, 5'h10, 8'h00, 4'h1);
        chk("unmapped", 8'h00, rd);
        bus(1'b1, {1'b0, DSGM_OFS_SRC}, 8'h01, 4'h0);
        rc("source", DSGM_OFS_SRC, 8'h8F);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        defaults();
        $display("test registers and reset done");
        // software bit picks high pin-one carrier or low reference carrier
        wr(DSGM_OFS_HIGH_CARRIER, 8'h01);
        wr(DSGM_OFS_LOW_CARRIER, 8'h03);
        for (int i = 0; i < 8; i++)
        begin
            set_lvl({4'h0, i[0], 1'b0, i[1], 1'b0});
            wr(DSGM_OFS_CTRL, {7'h70, i[2]});
            pin_is(i[2] ? i[1] : i[0]);
            rc("status", DSGM_OFS_CTRL, {4'hE, (i[2] ? i[1] : i[0]), 2'b00, i[2]});
        end
        $display("test mixing done");
        wr(DSGM_OFS_CTRL, 8'hE0);
        wr(DSGM_OFS_LOW_CARRIER, 8'h00);
        foreach (mcode[k])
        begin
            wr(DSGM_OFS_SRC, {4'h0, mcode[k]});
            set_lvl(mmask[k] | 8'h02);
            pin_is(mmask[k] != 8'h00);
            set_lvl(~mmask[k] | 8'h02);
            pin_is(1'b0);
        end
        $display("test modulator sources done");
        wr(DSGM_OFS_SRC, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                wr(DSGM_OFS_CTRL, {7'h70, s == 0});
                wr(s == 0 ? DSGM_OFS_HIGH_CARRIER : DSGM_OFS_LOW_CARRIER, k[7:0]);
                set_lvl(cmask(k, s[0]) != 8'h00 ? cmask(k, s[0]) : 8'hFF);
                pin_is(cmask(k, s[0]) != 8'h00);
                set_lvl(~cmask(k, s[0]));
                pin_is(1'b0);
            end
        end
        $display("test carrier sources done");
        wr(DSGM_OFS_HIGH_CARRIER, 8'h41);
        wr(DSGM_OFS_LOW_CARRIER, 8'h40);
        set_lvl(8'h00);
        pin_is(1'b1);
        wr(DSGM_OFS_CTRL, 8'hE1);
        pin_is(1'b1);
        set_lvl(8'h02);
        pin_is(1'b0);
        wr(DSGM_OFS_HIGH_CARRIER, 8'h01);
        wr(DSGM_OFS_CTRL, 8'hF1);
        pin_is(1'b0);
        rc("status", DSGM_OFS_CTRL, 8'hF9);
        wr(DSGM_OFS_CTRL, 8'hA1);
        pin_is(1'b0);
        rc("status", DSGM_OFS_CTRL, 8'hA9);
        wr(DSGM_OFS_CTRL, 8'hC1);
        pin_is(1'b1);
        chk("slew_limit", 8'h00, {7'h00, slew_limit});
        wr(DSGM_OFS_CTRL, 8'h61);
        pin_is(1'b0);
        rc("status", DSGM_OFS_CTRL, 8'h61);
        rc("high carrier", DSGM_OFS_HIGH_CARRIER, 8'h01);
        wr(DSGM_OFS_CTRL, 8'hE1);
        pin_is(1'b1);
        $display("test polarity, gating and enable done");
        wr(DSGM_OFS_SRC, 8'h8A);
        wr(DSGM_OFS_HIGH_CARRIER, 8'h83);
        wr(DSGM_OFS_LOW_CARRIER, 8'h84);
        repeat (4) @(posedge core_clk);
        chk("inhibit", 8'h13, {3'h0, inhibit});
        wr(DSGM_OFS_SRC, 8'h0A);
        repeat (4) @(posedge core_clk);
        chk("inhibit", 8'h11, {3'h0, inhibit});
        $display("test pin release done");
        // high sync holds the switch until the pwm carrier falls
        wr(DSGM_OFS_SRC, 8'h00);
        wr(DSGM_OFS_LOW_CARRIER, 8'h00);
        wr(DSGM_OFS_HIGH_CARRIER, 8'h24);
        set_lvl(8'h80);
        pin_is(1'b1);
        wr(DSGM_OFS_CTRL, 8'hE0);
        pin_is(1'b1);
        set_lvl(8'h00);
        pin_is(1'b0);
        set_lvl(8'h80);
        pin_is(1'b0);
        wr(DSGM_OFS_HIGH_CARRIER, 8'h04);
        wr(DSGM_OFS_CTRL, 8'hE1);
        pin_is(1'b1);
        wr(DSGM_OFS_LOW_CARRIER, 8'h20);
        wr(DSGM_OFS_CTRL, 8'hE0);
        pin_is(1'b0);
        // low sync on a ground carrier never sees a fall, so the switch stalls
        wr(DSGM_OFS_CTRL, 8'hE1);
        pin_is(1'b0);
        $display("test synchronisation done");
        finish_test();
    end
endmodule
`default_nettype wire
